// >>> core/cmbi_pkg.sv
// Package for the connection memory block fill: map, keys, timing, types
package cmbi_pkg;

  localparam logic [23:0] CMBI_ADDR_PATTERN   = 24'h04_0288;
  localparam logic [23:0] CMBI_ADDR_TRIGGER   = 24'h04_028C;
  localparam logic [31:0] CMBI_FILL_KEY       = 32'h3141_5926;
  localparam logic [31:0] CMBI_PATTERN_RESET  = 32'h0000_0000;
  localparam int          CMBI_STAT_FILL_BIT  = 0;
  localparam int          CMBI_STAT_RESET_BIT = 1;
  // Memory geometry; the fill walks every word once
  localparam int          CMBI_MEM_WORDS      = 24576;
  localparam int          CMBI_ADDR_W         = 15;
  localparam logic [14:0] CMBI_LAST_ADDR      = 15'h5FFF;
  localparam logic [14:0] CMBI_ADDR_ZERO      = 15'h0000;
  // One word per cycle: 24576 cycles, about 123 us at 200 MHz
  // A slower pace would stretch the fill far past its time
  localparam int          CMBI_WORD_CYCLES    = 1;
  localparam int          CMBI_FILL_CYCLES    = CMBI_MEM_WORDS * CMBI_WORD_CYCLES;
  localparam int          CMBI_PACE_W         = 4;
  localparam logic [3:0]  CMBI_PACE_LAST      = 4'(CMBI_WORD_CYCLES - 1);
  localparam logic [3:0]  CMBI_PACE_ZERO      = 4'h0;
  // Reset initialization length in cycles, arbitrary small figure
  localparam logic [7:0]  CMBI_RSTINIT_CYCLES = 8'h40;
  localparam logic [7:0]  CMBI_RSTINIT_ZERO   = 8'h00;

  typedef enum logic [1:0] {
    CMBI_IDLE,
    CMBI_FILL
  } cmbi_state_type;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic        memAccess;
  } cmbi_req_type;

  typedef struct packed {
    logic                   we;
    logic [CMBI_ADDR_W-1:0] addr;
    logic [31:0]            data;
  } cmbi_memwr_type;

endpackage

// >>> core/cmbi_pace.sv
// Word pacing counter: pulses once per word slot while running
module cmbi_pace
  import cmbi_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      tick
);

  logic [CMBI_PACE_W-1:0] count;
  logic [CMBI_PACE_W-1:0] next_count;

  always_comb begin
    next_count = CMBI_PACE_ZERO;
    if (run && count != CMBI_PACE_LAST) begin
      next_count = count + 4'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count <= CMBI_PACE_ZERO;
    end else begin
      count <= next_count;
    end
  end

  assign tick = run && (count == CMBI_PACE_LAST);

endmodule

// >>> core/cmbi_block_init.sv
// Connection memory block fill engine with pattern and trigger registers
// Operation
// - Pattern register: 32-bit read/write, holds the fill word.
// - Trigger register: key writes start a fill, reads return status.
// - A fill runs by itself after power-up.
// - Pattern register clears at power-up, so first fill writes zeros unless a pattern is written first.
// - Fill writes the pattern to every memory word in about 120 us.
// - Pattern changes during a fill do not affect that fill.
// - Writing key 31415926 hex to the trigger starts a fill.
// - Fill requests (key writes) during a running fill are ignored; pattern writes are still taken.
// - Status bit 0 is one while a fill runs.
// - Status bit 1 is one while reset initialization runs.
// - Status bits 31 to 2 always read zero.
// - Memory accesses during fill or reset init end in bus fault.
// - TDM outputs stay high impedance throughout any fill.
module cmbi_block_init
  import cmbi_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     srst,
  input  cmbi_req_type  busReq,
  output logic [31:0]   busRdata,
  output logic          bus_fault_flag,
  output cmbi_memwr_type memWr,
  output logic          tdmHighZ,
  output logic          fillBusy,
  output logic          resetInitBusy
);

  ////////////////////////////////////////////////////////////////////////
  // State

  cmbi_state_type         state;
  cmbi_state_type         next_state;
  logic [31:0]            pattern;
  logic [31:0]            next_pattern;
  logic [31:0]            fillWord;
  logic [31:0]            next_fillWord;
  logic [CMBI_ADDR_W-1:0] fillAddr;
  logic [CMBI_ADDR_W-1:0] next_fillAddr;
  logic [7:0]             rstCount;
  logic [7:0]             next_rstCount;
  logic                   next_resetInitBusy;
  logic                   next_fillBusy;
  logic                   pendingBoot;
  logic                   next_pendingBoot;
  logic [31:0]            next_busRdata;
  logic                   next_fault;
  cmbi_memwr_type         next_memWr;
  logic                   wordTick;
  logic                   keyWrite;
  logic                   fillRun;
  logic                   patternWrite;
  logic                   bootDue;
  logic                   busyAny;

  assign fillRun = state == CMBI_FILL;

  cmbi_pace u_pace (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (fillRun),
    .tick    (wordTick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign patternWrite = busReq.sel && busReq.wr && busReq.addr == CMBI_ADDR_PATTERN;
  assign keyWrite     = busReq.sel && busReq.wr && busReq.addr == CMBI_ADDR_TRIGGER
                        && busReq.wdata == CMBI_FILL_KEY;
  // Boot fill waits for reset init so it uses a pattern written during init
  assign bootDue      = pendingBoot && !resetInitBusy;
  // Memory is off limits while either initialization runs
  assign busyAny      = fillBusy || resetInitBusy;

  ////////////////////////////////////////////////////////////////////////
  // Reset initialization

  always_comb begin
    next_rstCount      = rstCount;
    next_resetInitBusy = resetInitBusy;
    if (resetInitBusy) begin
      if (rstCount == CMBI_RSTINIT_ZERO) begin
        next_resetInitBusy = 1'h0;
      end else begin
        next_rstCount = rstCount - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rstCount      <= CMBI_RSTINIT_CYCLES;
      resetInitBusy <= 1'h1;
    end else begin
      rstCount      <= next_rstCount;
      resetInitBusy <= next_resetInitBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern register

  always_comb begin
    next_pattern = pattern;
    if (patternWrite) begin
      // A running fill keeps its own copy
      next_pattern = busReq.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pattern <= CMBI_PATTERN_RESET;
    end else begin
      pattern <= next_pattern;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    next_busRdata = busRdata;
    if (busReq.sel && !busReq.wr) begin
      next_busRdata = '0;
      if (busReq.addr == CMBI_ADDR_PATTERN) begin
        next_busRdata = pattern;
      end else if (busReq.addr == CMBI_ADDR_TRIGGER) begin
        // Status, never the last written word
        next_busRdata[CMBI_STAT_FILL_BIT]  = fillBusy;
        next_busRdata[CMBI_STAT_RESET_BIT] = resetInitBusy;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busRdata <= '0;
    end else begin
      busRdata <= next_busRdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus fault

  always_comb begin
    next_fault = 1'h0;
    if (busReq.sel && busReq.memAccess && busyAny) begin
      next_fault = 1'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_fault_flag <= 1'h0;
    end else begin
      bus_fault_flag <= next_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fill sequencer

  always_comb begin
    next_state       = state;
    next_pendingBoot = pendingBoot;
    next_fillWord    = fillWord;
    next_fillAddr    = fillAddr;
    next_memWr       = '0;

    case (state)
      CMBI_IDLE: begin
        // A key beside the last word in flight is dropped as well
        if (!fillBusy && (bootDue || keyWrite)) begin
          next_state       = CMBI_FILL;
          next_pendingBoot = 1'h0;
          next_fillWord    = pattern;
          next_fillAddr    = CMBI_ADDR_ZERO;
        end
      end
      CMBI_FILL: begin
        // keyWrite not looked at here: a repeat request is dropped
        if (wordTick) begin
          next_memWr.we   = 1'h1;
          next_memWr.addr = fillAddr;
          next_memWr.data = fillWord;
          if (fillAddr == CMBI_LAST_ADDR) begin
            next_state = CMBI_IDLE;
          end else begin
            next_fillAddr = fillAddr + 15'h0001;
          end
        end
      end
      default: begin
        next_state = CMBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state       <= CMBI_IDLE;
      pendingBoot <= 1'h1;
      fillWord    <= CMBI_PATTERN_RESET;
      fillAddr    <= CMBI_ADDR_ZERO;
      memWr       <= '0;
    end else begin
      state       <= next_state;
      pendingBoot <= next_pendingBoot;
      fillWord    <= next_fillWord;
      fillAddr    <= next_fillAddr;
      memWr       <= next_memWr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Busy flags

  always_comb begin
    // Busy also covers the last word still on its way to memory
    next_fillBusy = (next_state == CMBI_FILL) || next_memWr.we;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fillBusy <= 1'h0;
      tdmHighZ <= 1'h0;
    end else begin
      fillBusy <= next_fillBusy;
      tdmHighZ <= next_fillBusy;
    end
  end

endmodule

// >>> tb/cmbi_checker.sv
// Checker: bus, fill and status timing of the block fill engine
module cmbi_checker
  import cmbi_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           srst,
  input wire cmbi_req_type   busReq,
  input wire logic [31:0]    busRdata,
  input wire logic           bus_fault_flag,
  input wire cmbi_memwr_type memWr,
  input wire logic           tdmHighZ,
  input wire logic           fillBusy,
  input wire logic           resetInitBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire trg = busReq.sel && busReq.addr == CMBI_ADDR_TRIGGER;
  wire idle = !fillBusy && !resetInitBusy;
  wire key = busReq.wdata == CMBI_FILL_KEY;
  property p_boot; $fell(resetInitBusy) |-> ##[0:2] fillBusy; endproperty
  a_boot: assert property (p_boot) else $error("no boot fill");
  property p_flt; busReq.sel && busReq.memAccess && !idle |=> bus_fault_flag; endproperty
  a_flt: assert property (p_flt) else $error("no fault");
  property p_st; trg && !busReq.wr |=> busRdata == {30'h0, $past(resetInitBusy), $past(fillBusy)};
  endproperty
  a_st: assert property (p_st) else $error("bad status");
  property p_key; trg && busReq.wr && key && idle |=> fillBusy; endproperty
  a_key: assert property (p_key) else $error("key ignored");
  // Boot fill may still be pending just after init ends
  property p_nk; trg && busReq.wr && !key && idle && !$past(resetInitBusy, 3) |=> !fillBusy;
  endproperty
  a_nk: assert property (p_nk) else $error("non-key start");
  property p_we; memWr.we |-> fillBusy && tdmHighZ; endproperty
  a_we: assert property (p_we) else $error("stray write");
  property p_first; $rose(fillBusy) |-> ##[0:8] memWr.we && memWr.addr == CMBI_ADDR_ZERO; endproperty
  a_first: assert property (p_first) else $error("no first word");
  property p_step; memWr.we && memWr.addr != CMBI_LAST_ADDR |-> ##1 memWr.we &&
    memWr.addr == $past(memWr.addr) + 15'h1 && memWr.data == $past(memWr.data); endproperty
  a_step: assert property (p_step) else $error("bad walk");
  property p_hiz; tdmHighZ == fillBusy; endproperty
  a_hiz: assert property (p_hiz) else $error("outputs driven");
endmodule

// >>> tb/cmbi_host.sv
// Host processor model: single-cycle strobed accesses
module cmbi_host
  import cmbi_pkg::*;
(
  input  wire logic        sys_clk,
  output cmbi_req_type     busReq,
  input  wire logic [31:0] busRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial busReq = '0;
  // Strobe drops at the taking edge; data lines then stop showing the last word
  task automatic acc(input logic w, m, input logic [23:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    busReq <= '{1'h1, w, a, d, m};
    @(posedge sys_clk);
    busReq.sel <= 1'h0;
    busReq.wdata <= ~d;
    #1 q = busRdata;
  endtask
endmodule

// >>> tb/tb_top.sv
// Testbench: boot fill, refusals during a fill, host-started fill
module tb_top
  import cmbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin badCount++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end
  logic sys_clk, srst, bus_fault_flag, tdmHighZ, fillBusy, resetInitBusy;
  logic [31:0] busRdata, expPat, q;
  cmbi_req_type busReq;
  cmbi_memwr_type memWr;
  int badCount = 0, checks = 0, words = 0;
  cmbi_block_init uut (.sys_clk, .srst, .busReq, .busRdata, .bus_fault_flag, .memWr,
    .tdmHighZ, .fillBusy, .resetInitBusy);
  cmbi_host host (.sys_clk, .busReq, .busRdata);
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (memWr.we === 1'h1) begin
      words++;
      `CHK(memWr.data, expPat)
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic waitFor(input logic lvl);
    int n;
    n = 0;
    // Flag is looked at once the edge has settled it
    while (fillBusy !== lvl) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > CMBI_FILL_CYCLES + 1000) begin
        badCount++;
        conclude();
      end
    end
  endtask
  task automatic bootCheck();
    host.acc('0, '0, CMBI_ADDR_TRIGGER, '0, q);
    `CHK(q, 32'h0000_0002)
    host.acc('0, '0, CMBI_ADDR_PATTERN, '0, q);
    `CHK(q, CMBI_PATTERN_RESET)
    host.acc('0, '1, '0, '0, q);
    `CHK(bus_fault_flag, 1'h1)
    waitFor('1);
    `CHK(tdmHighZ, 1'h1)
  endtask
  task automatic fillRefusals();
    host.acc('1, '0, CMBI_ADDR_PATTERN, 32'hA5A5_5A5A, q);
    host.acc('1, '0, CMBI_ADDR_TRIGGER, CMBI_FILL_KEY, q);
    host.acc('0, '0, CMBI_ADDR_PATTERN, '0, q);
    `CHK(q, 32'hA5A5_5A5A)
    host.acc('0, '0, CMBI_ADDR_TRIGGER, '0, q);
    `CHK(q, 32'h0000_0001)
    host.acc('0, '1, 24'h00_0010, '0, q);
    `CHK(bus_fault_flag, 1'h1)
  endtask
  task automatic hostFill();
    waitFor('0);
    `CHK(words, CMBI_MEM_WORDS)
    `CHK(tdmHighZ, 1'h0)
    host.acc('0, '0, CMBI_ADDR_TRIGGER, '0, q);
    `CHK(q, 32'h0000_0000)
    host.acc('0, '1, '0, '0, q);
    `CHK(bus_fault_flag, 1'h0)
    host.acc('1, '0, CMBI_ADDR_TRIGGER, 32'h3141_5927, q);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(fillBusy, 1'h0)
    host.acc('0, '0, CMBI_ADDR_TRIGGER, '0, q);
    `CHK(q, 32'h0000_0000)
    expPat = 32'hA5A5_5A5A;
    host.acc('1, '0, CMBI_ADDR_TRIGGER, CMBI_FILL_KEY, q);
    `CHK(fillBusy, 1'h1)
    `CHK(tdmHighZ, 1'h1)
    waitFor('0);
    `CHK(words, 2 * CMBI_MEM_WORDS)
  endtask
  initial begin
    srst = 1'h1;
    expPat = CMBI_PATTERN_RESET;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    bootCheck();
    fillRefusals();
    hostFill();
    conclude();
  end
endmodule
bind cmbi_block_init cmbi_checker chk (.sys_clk, .srst, .busReq, .busRdata, .bus_fault_flag,
  .memWr, .tdmHighZ, .fillBusy, .resetInitBusy);
